// ### hw/energy_accum_consts.vh
// Constants for the energy accumulation mode configuration block.
// Assumes inclusion by its bare name from the design files of that block.
`ifndef ENERGY_ACCUM_CONSTS_VH
`define ENERGY_ACCUM_CONSTS_VH

// Width of one signed power sample per phase and quantity.
`define PWR_W              24
// Register addresses on the plain register port.
`define ADDR_MODE_SELECT   16'he700
`define ADDR_ACCUM_MODE    16'he701
`define ADDR_REV_STATE     16'he703
// Reset values of the two configuration registers.
`define RST_MODE_SELECT    8'h1c
`define RST_ACCUM_MODE     8'h00
// Field positions in the metering mode select register.
`define ACT_REV_SEL_BIT    0
`define REA_REV_SEL_BIT    1
`define PEAK_EN_LSB        2
`define PEAK_EN_MSB        4
// Field positions in the energy accumulation mode register.
`define ACT_MODE_LSB       0
`define ACT_MODE_MSB       1
`define REA_MODE_LSB       2
`define REA_MODE_MSB       3
// Accumulation mode codes.
`define MODE_SIGNED        2'h0
`define MODE_ACT_POS_ONLY  2'h1
`define MODE_REA_BY_ACT    2'h2
`define MODE_ABSOLUTE      2'h3
// Positions of the reversal events in status register zero.
`define STAT0_ACT_REV_LSB  6
`define STAT0_REA_REV_LSB  10
`define STAT0_W            16

`endif

// ### hw/reversal_detector.v
// Sign reversal detector for one phase and one kind of power.
// Assumes sign bits come from logic on the same clock, sampled on i_valid.
`timescale 1ns/1ns
`include "energy_accum_consts.vh"

module reversal_detector (
  input  wire i_clk_sys,   // System clock.
  input  wire i_arst_n,    // Asynchronous reset, active low.
  input  wire i_valid,     // New power sample present.
  input  wire i_sel_fund,  // Selects the fundamental power when high.
  input  wire i_sign_tot,  // Sign of the total power, high when negative.
  input  wire i_sign_fund, // Sign of the fundamental power, high when negative.
  output wire o_rev_next,  // High in the cycle a sign change is seen.
  output wire o_sign       // Last sampled sign of the selected power.
);

  reg  sign_reg;   // Sign of the selected power at the previous sample.
  reg  seen_reg;   // A first sample has been taken since reset.
  wire sign_now;   // Sign of the currently selected power.

  // The select bit picks total or fundamental power as the source.
  assign sign_now   = i_sel_fund ? i_sign_fund : i_sign_tot;
  // A change of sign on a valid sample marks a reversal.
  assign o_rev_next = i_valid & seen_reg & (sign_now != sign_reg);
  assign o_sign     = sign_reg;

  // Keeps the previous sign so that the next sample can be compared.
  always @(posedge i_clk_sys or negedge i_arst_n) begin
    if (!i_arst_n) begin
      sign_reg <= 1'b0;
      seen_reg <= 1'b0;
    end else if (i_valid) begin
      sign_reg <= sign_now;
      seen_reg <= 1'b1;
    end
  end

endmodule // reversal_detector

// ### hw/power_conditioner.v
// Per-phase conditioning of active and reactive powers before accumulation.
// Assumes powers are signed samples from logic on the same clock.
`timescale 1ns/1ns
`include "energy_accum_consts.vh"

module power_conditioner (
  input  wire                     i_clk_sys,    // System clock.
  input  wire                     i_arst_n,     // Asynchronous reset, active low.
  input  wire                     i_valid,      // New samples present.
  input  wire [1:0]               i_act_mode,   // Active accumulation mode.
  input  wire [1:0]               i_rea_mode,   // Reactive accumulation mode.
  input  wire signed [`PWR_W-1:0] i_act_tot,    // Total active power.
  input  wire signed [`PWR_W-1:0] i_act_fund,   // Fundamental active power.
  input  wire signed [`PWR_W-1:0] i_rea_tot,    // Total reactive power.
  input  wire signed [`PWR_W-1:0] i_rea_fund,   // Fundamental reactive power.
  output reg  signed [`PWR_W-1:0] o_act_tot_e,  // Total active, energy path.
  output reg  signed [`PWR_W-1:0] o_act_fund_e, // Fundamental active, energy path.
  output reg  signed [`PWR_W-1:0] o_act_tot_f,  // Total active, pulse path.
  output reg  signed [`PWR_W-1:0] o_act_fund_f, // Fundamental active, pulse path.
  output reg  signed [`PWR_W-1:0] o_rea_tot_e,  // Total reactive, energy path.
  output reg  signed [`PWR_W-1:0] o_rea_fund_e, // Fundamental reactive, energy path.
  output reg  signed [`PWR_W-1:0] o_rea_tot_f,  // Total reactive, pulse path.
  output reg  signed [`PWR_W-1:0] o_rea_fund_f  // Fundamental reactive, pulse path.
);

  // Negation that saturates the most negative value instead of wrapping.
  function signed [`PWR_W-1:0] neg_sat;
    input signed [`PWR_W-1:0] v;
    begin
      if (v == {1'b1, {(`PWR_W-1){1'b0}}}) begin
        neg_sat = {1'b0, {(`PWR_W-1){1'b1}}};
      end else begin
        neg_sat = -v;
      end
    end
  endfunction

  // Absolute value, built on the saturating negation.
  function signed [`PWR_W-1:0] abs_sat;
    input signed [`PWR_W-1:0] v;
    begin
      abs_sat = v[`PWR_W-1] ? neg_sat(v) : v;
    end
  endfunction

  // Applies the selected modes on each valid sample; outputs hold otherwise.
  always @(posedge i_clk_sys or negedge i_arst_n) begin
    if (!i_arst_n) begin
      o_act_tot_e  <= {`PWR_W{1'b0}};
      o_act_fund_e <= {`PWR_W{1'b0}};
      o_act_tot_f  <= {`PWR_W{1'b0}};
      o_act_fund_f <= {`PWR_W{1'b0}};
      o_rea_tot_e  <= {`PWR_W{1'b0}};
      o_rea_fund_e <= {`PWR_W{1'b0}};
      o_rea_tot_f  <= {`PWR_W{1'b0}};
      o_rea_fund_f <= {`PWR_W{1'b0}};
    end else if (i_valid) begin
      case (i_act_mode)
        `MODE_ACT_POS_ONLY: begin
          // Energy sees only positive power, pulses stay signed.
          o_act_tot_e  <= (i_act_tot > 0) ? i_act_tot : {`PWR_W{1'b0}};
          o_act_fund_e <= (i_act_fund > 0) ? i_act_fund : {`PWR_W{1'b0}};
          o_act_tot_f  <= i_act_tot;
          o_act_fund_f <= i_act_fund;
        end
        `MODE_ABSOLUTE: begin
          // Both paths see the magnitude.
          o_act_tot_e  <= abs_sat(i_act_tot);
          o_act_fund_e <= abs_sat(i_act_fund);
          o_act_tot_f  <= abs_sat(i_act_tot);
          o_act_fund_f <= abs_sat(i_act_fund);
        end
        default: begin
          // Signed mode, also taken by the reserved code.
          o_act_tot_e  <= i_act_tot;
          o_act_fund_e <= i_act_fund;
          o_act_tot_f  <= i_act_tot;
          o_act_fund_f <= i_act_fund;
        end
      endcase
      case (i_rea_mode)
        `MODE_REA_BY_ACT: begin
          // Reactive sign follows the matching active power sign.
          o_rea_tot_e  <= i_act_tot[`PWR_W-1] ? neg_sat(i_rea_tot) : i_rea_tot;
          o_rea_fund_e <= i_act_fund[`PWR_W-1] ? neg_sat(i_rea_fund) : i_rea_fund;
          o_rea_tot_f  <= i_act_tot[`PWR_W-1] ? neg_sat(i_rea_tot) : i_rea_tot;
          o_rea_fund_f <= i_act_fund[`PWR_W-1] ? neg_sat(i_rea_fund) : i_rea_fund;
        end
        `MODE_ABSOLUTE: begin
          // Both paths see the magnitude.
          o_rea_tot_e  <= abs_sat(i_rea_tot);
          o_rea_fund_e <= abs_sat(i_rea_fund);
          o_rea_tot_f  <= abs_sat(i_rea_tot);
          o_rea_fund_f <= abs_sat(i_rea_fund);
        end
        default: begin
          // Signed mode, also taken by the reserved code.
          o_rea_tot_e  <= i_rea_tot;
          o_rea_fund_e <= i_rea_fund;
          o_rea_tot_f  <= i_rea_tot;
          o_rea_fund_f <= i_rea_fund;
        end
      endcase
    end
  end

endmodule // power_conditioner

// ### hw/energy_accum_mode_config.v
// Configuration registers and power conditioning of a polyphase metering engine.
// Assumes the register port and the power samples are driven on i_clk_sys.
//
// Contract
// - Active reversal source: total at 0, fundamental at 1.
// - Active reversal phases A,B,C set status bits 6,7,8.
// - Reactive reversal source: total at 0, fundamental at 1.
// - Reactive reversal phases A,B,C set status bits 10,11,12.
// - Bits 2..4 enable phase peak detection, reset one.
// - Mode select bits 7..5 reset zero, no effect.
// - Active code 00: signed energy and pulses.
// - Active code 01: positive-only energy, signed pulses.
// - Active code 10 behaves as code 00.
// - Active code 11: absolute energy and pulses.
// - Reactive code 00: signed energy and pulses.
// - Reactive code 01 behaves as code 00.
// - Reactive code 10: sign follows matching active power.
// - Reactive code 11: absolute energy and pulses.
`timescale 1ns/1ns
`include "energy_accum_consts.vh"

module energy_accum_mode_config (
  input  wire                      i_clk_sys,       // System clock, 25 MHz.
  input  wire                      i_arst_n,        // Asynchronous reset, active low.
  input  wire                      i_soft_reset,    // Software reset pulse.
  input  wire [15:0]               i_addr,          // Register address.
  input  wire [7:0]                i_wr_data,       // Register write data.
  input  wire                      i_wr_en,         // Write strobe.
  input  wire                      i_rd_en,         // Read strobe.
  output wire [7:0]                o_rd_data,       // Read data, one cycle after the strobe.
  input  wire                      i_power_valid,   // New power samples present.
  input  wire [3*`PWR_W-1:0]       i_act_tot,       // Total active power, phase A lowest.
  input  wire [3*`PWR_W-1:0]       i_act_fund,      // Fundamental active power.
  input  wire [3*`PWR_W-1:0]       i_rea_tot,       // Total reactive power.
  input  wire [3*`PWR_W-1:0]       i_rea_fund,      // Fundamental reactive power.
  output wire [2:0]                o_peak_phase_enable, // Phase C..A take part in peak detection.
  output wire [`STAT0_W-1:0]       o_status_zero_set, // Set pulses for status register zero.
  output wire                      o_accum_valid,   // Conditioned samples updated.
  output wire [3*`PWR_W-1:0]       o_act_tot_energy,   // Total active to energy registers.
  output wire [3*`PWR_W-1:0]       o_act_fund_energy,  // Fundamental active to energy registers.
  output wire [3*`PWR_W-1:0]       o_act_tot_pulse,    // Total active to pulse outputs.
  output wire [3*`PWR_W-1:0]       o_act_fund_pulse,   // Fundamental active to pulse outputs.
  output wire [3*`PWR_W-1:0]       o_rea_tot_energy,   // Total reactive to energy registers.
  output wire [3*`PWR_W-1:0]       o_rea_fund_energy,  // Fundamental reactive to energy registers.
  output wire [3*`PWR_W-1:0]       o_rea_tot_pulse,    // Total reactive to pulse outputs.
  output wire [3*`PWR_W-1:0]       o_rea_fund_pulse    // Fundamental reactive to pulse outputs.
);

  // Configuration and port registers.
  reg  [7:0]            mode_select_reg;    // Metering mode select register.
  reg  [7:0]            accum_mode_reg;     // Energy accumulation mode register.
  reg  [7:0]            rd_data_reg;        // Read data held for one cycle.
  reg  [7:0]            rd_data_next;       // Read data chosen by the address.
  reg  [`STAT0_W-1:0]   status_set_reg;     // Registered status set pulses.
  reg                   accum_valid_reg;    // Follows the conditioner update.
  reg  [2:0]            peak_en_reg;        // Registered peak enables.

  // Per-phase results of the reversal detectors.
  wire [2:0]            act_rev;            // Active reversal seen this cycle.
  wire [2:0]            rea_rev;            // Reactive reversal seen this cycle.
  wire [2:0]            act_sign;           // Last sign of selected active power.
  wire [2:0]            rea_sign;           // Last sign of selected reactive power.
  wire [`STAT0_W-1:0]   status_set_next;    // Status set pulses before the register.

  // Decoded fields.
  wire                  act_rev_sel;        // Active reversal source select.
  wire                  rea_rev_sel;        // Reactive reversal source select.
  wire [1:0]            act_mode;           // Active accumulation mode.
  wire [1:0]            rea_mode;           // Reactive accumulation mode.

  assign act_rev_sel = mode_select_reg[`ACT_REV_SEL_BIT];
  assign rea_rev_sel = mode_select_reg[`REA_REV_SEL_BIT];
  assign act_mode    = accum_mode_reg[`ACT_MODE_MSB:`ACT_MODE_LSB];
  assign rea_mode    = accum_mode_reg[`REA_MODE_MSB:`REA_MODE_LSB];
  // The upper bits of the mode select register are stored and read back,
  // but no logic below looks at them.

  // Writes to the configuration registers; software reset restores defaults.
  always @(posedge i_clk_sys or negedge i_arst_n) begin
    if (!i_arst_n) begin
      mode_select_reg <= `RST_MODE_SELECT;
      accum_mode_reg  <= `RST_ACCUM_MODE;
    end else if (i_soft_reset) begin
      // Software reset has priority over a write in the same cycle.
      mode_select_reg <= `RST_MODE_SELECT;
      accum_mode_reg  <= `RST_ACCUM_MODE;
    end else if (i_wr_en) begin
      if (i_addr == `ADDR_MODE_SELECT) begin
        mode_select_reg <= i_wr_data;
      end
      if (i_addr == `ADDR_ACCUM_MODE) begin
        accum_mode_reg <= i_wr_data;
      end
    end
  end

  // Read multiplexer; unmapped addresses read as zero.
  always @* begin
    rd_data_next = 8'h00;
    case (i_addr)
      `ADDR_MODE_SELECT: begin
        rd_data_next = mode_select_reg;
      end
      `ADDR_ACCUM_MODE: begin
        rd_data_next = accum_mode_reg;
      end
      `ADDR_REV_STATE: begin
        // Current sign state of the selected powers per phase.
        rd_data_next = {2'h0, rea_sign, act_sign};
      end
      default: begin
        rd_data_next = 8'h00;
      end
    endcase
  end

  // Read data stand only in the cycle after the read strobe.
  always @(posedge i_clk_sys or negedge i_arst_n) begin
    if (!i_arst_n) begin
      rd_data_reg <= 8'h00;
    end else if (i_rd_en) begin
      rd_data_reg <= rd_data_next;
    end else begin
      rd_data_reg <= 8'h00;
    end
  end

  // Per-phase conditioning and reversal detection.
  genvar ph;
  generate
    for (ph = 0; ph < 3; ph = ph + 1) begin : g_phase
      // Reversal of the selected active power.
      reversal_detector u_act_rev (
        .i_clk_sys   (i_clk_sys),
        .i_arst_n    (i_arst_n),
        .i_valid     (i_power_valid),
        .i_sel_fund  (act_rev_sel),
        .i_sign_tot  (i_act_tot[ph*`PWR_W+`PWR_W-1]),
        .i_sign_fund (i_act_fund[ph*`PWR_W+`PWR_W-1]),
        .o_rev_next  (act_rev[ph]),
        .o_sign      (act_sign[ph])
      );
      // Reversal of the selected reactive power.
      reversal_detector u_rea_rev (
        .i_clk_sys   (i_clk_sys),
        .i_arst_n    (i_arst_n),
        .i_valid     (i_power_valid),
        .i_sel_fund  (rea_rev_sel),
        .i_sign_tot  (i_rea_tot[ph*`PWR_W+`PWR_W-1]),
        .i_sign_fund (i_rea_fund[ph*`PWR_W+`PWR_W-1]),
        .o_rev_next  (rea_rev[ph]),
        .o_sign      (rea_sign[ph])
      );
      // Accumulation mode handling for this phase.
      power_conditioner u_cond (
        .i_clk_sys    (i_clk_sys),
        .i_arst_n     (i_arst_n),
        .i_valid      (i_power_valid),
        .i_act_mode   (act_mode),
        .i_rea_mode   (rea_mode),
        .i_act_tot    (i_act_tot[ph*`PWR_W +: `PWR_W]),
        .i_act_fund   (i_act_fund[ph*`PWR_W +: `PWR_W]),
        .i_rea_tot    (i_rea_tot[ph*`PWR_W +: `PWR_W]),
        .i_rea_fund   (i_rea_fund[ph*`PWR_W +: `PWR_W]),
        .o_act_tot_e  (o_act_tot_energy[ph*`PWR_W +: `PWR_W]),
        .o_act_fund_e (o_act_fund_energy[ph*`PWR_W +: `PWR_W]),
        .o_act_tot_f  (o_act_tot_pulse[ph*`PWR_W +: `PWR_W]),
        .o_act_fund_f (o_act_fund_pulse[ph*`PWR_W +: `PWR_W]),
        .o_rea_tot_e  (o_rea_tot_energy[ph*`PWR_W +: `PWR_W]),
        .o_rea_fund_e (o_rea_fund_energy[ph*`PWR_W +: `PWR_W]),
        .o_rea_tot_f  (o_rea_tot_pulse[ph*`PWR_W +: `PWR_W]),
        .o_rea_fund_f (o_rea_fund_pulse[ph*`PWR_W +: `PWR_W])
      );
    end
  endgenerate

  // Places the reversal events at their status register zero positions.
  assign status_set_next = ({13'h0, act_rev} << `STAT0_ACT_REV_LSB)
                         | ({13'h0, rea_rev} << `STAT0_REA_REV_LSB);

  // Output registers for status pulses, valid and peak enables.
  always @(posedge i_clk_sys or negedge i_arst_n) begin
    if (!i_arst_n) begin
      status_set_reg  <= {`STAT0_W{1'b0}};
      accum_valid_reg <= 1'b0;
      peak_en_reg     <= 3'h7;
    end else begin
      status_set_reg  <= status_set_next;
      accum_valid_reg <= i_power_valid;
      peak_en_reg     <= mode_select_reg[`PEAK_EN_MSB:`PEAK_EN_LSB];
    end
  end

  assign o_rd_data           = rd_data_reg;
  assign o_status_zero_set   = status_set_reg;
  assign o_accum_valid       = accum_valid_reg;
  assign o_peak_phase_enable = peak_en_reg;

endmodule // energy_accum_mode_config

// ### sim/energy_accum_mode_config_asserts.sv
// Port checker for the accumulation mode configuration block.
// Assumes one clock domain and binding to the top module.
`timescale 1ns/1ns
`include "energy_accum_consts.vh"
module energy_accum_mode_config_asserts (
  input wire        i_clk_sys,
  input wire        i_arst_n,
  input wire        i_soft_reset,
  input wire [15:0] i_addr,
  input wire [7:0]  i_wr_data,
  input wire        i_wr_en,
  input wire        i_rd_en,
  input wire [7:0]  o_rd_data,
  input wire        i_power_valid,
  input wire [2:0]  o_peak_phase_enable,
  input wire [15:0] o_status_zero_set,
  input wire        o_accum_valid,
  input wire [71:0] o_act_tot_energy,
  input wire [71:0] o_act_tot_pulse,
  input wire [71:0] o_rea_tot_energy,
  input wire [71:0] o_rea_tot_pulse
);
  // Shadow of the accumulation mode fields, kept from the register port.
  reg [3:0] mode_reg;
  wire signed [23:0] ae = o_act_tot_energy[23:0]; // Phase A active energy path.
  wire signed [23:0] ap = o_act_tot_pulse[23:0];  // Phase A active pulse path.
  wire signed [23:0] re = o_rea_tot_energy[23:0]; // Phase A reactive energy path.
  wire signed [23:0] rp = o_rea_tot_pulse[23:0];  // Phase A reactive pulse path.

  // Soft reset wins over a write in the same cycle.
  always @(posedge i_clk_sys or negedge i_arst_n) begin
    if (!i_arst_n)
      mode_reg <= 4'h0;
    else if (i_soft_reset)
      mode_reg <= 4'h0;
    else if (i_wr_en && i_addr == 16'he701)
      mode_reg <= i_wr_data[3:0];
  end

  default clocking cb @(posedge i_clk_sys); endclocking
  default disable iff (!i_arst_n);

  valid_to_accum_a: assert property (i_power_valid |=> o_accum_valid)
    else $error("accum valid did not follow a sample");
  accum_from_valid_a: assert property (o_accum_valid |-> $past(i_power_valid))
    else $error("accum valid without a sample");
  status_bits_a: assert property ((o_status_zero_set & 16'he23f) == 16'h0)
    else $error("status set pulse on an unused bit");
  status_timing_a: assert property (o_status_zero_set != 16'h0 |-> $past(i_power_valid))
    else $error("status set pulse without a sample");
  peak_write_a: assert property ((i_wr_en && !i_soft_reset && i_addr == 16'he700)
    |-> ##2 o_peak_phase_enable == $past(i_wr_data[4:2], 2))
    else $error("peak enables do not follow the write");
  soft_default_a: assert property (i_soft_reset |-> ##2 o_peak_phase_enable == 3'h7)
    else $error("soft reset did not restore peak enables");
  rd_idle_a: assert property (!i_rd_en |=> o_rd_data == 8'h00)
    else $error("read data not zero outside a read");
  rd_mode_a: assert property ((i_rd_en && i_addr == 16'he701) |=> o_rd_data[3:0] == $past(mode_reg))
    else $error("mode read back differs");
  act_pos_only_a: assert property ((o_accum_valid && $past(mode_reg[1:0]) == 2'h1)
    |-> ae == (ap < 0 ? 24'sd0 : ap))
    else $error("positive only energy wrong");
  act_abs_a: assert property ((o_accum_valid && $past(mode_reg[1:0]) == 2'h3) |-> !ap[23] && ae == ap)
    else $error("absolute active wrong");
  rea_abs_a: assert property ((o_accum_valid && $past(mode_reg[3:2]) == 2'h3) |-> !rp[23] && re == rp)
    else $error("absolute reactive wrong");
endmodule // energy_accum_mode_config_asserts

bind energy_accum_mode_config energy_accum_mode_config_asserts i_chk (.i_clk_sys, .i_arst_n, .i_soft_reset,
  .i_addr, .i_wr_data, .i_wr_en, .i_rd_en, .o_rd_data, .i_power_valid, .o_peak_phase_enable, .o_status_zero_set,
  .o_accum_valid, .o_act_tot_energy, .o_act_tot_pulse, .o_rea_tot_energy, .o_rea_tot_pulse);

// ### sim/energy_accum_mode_config_bench.sv
// Self-checking bench for the accumulation mode configuration block.
// Assumes the design and its constants header are compiled alongside.
`timescale 1ns/1ns
`include "energy_accum_consts.vh"
module energy_accum_mode_config_bench;
  reg        i_clk_sys = 1'b0;
  reg        i_arst_n = 1'b0;
  reg        i_soft_reset = 1'b0;
  reg [15:0] i_addr = 16'h0;
  reg [7:0]  i_wr_data = 8'h0;
  reg        i_wr_en = 1'b0;
  reg        i_rd_en = 1'b0;
  reg        i_power_valid = 1'b0;
  reg [71:0] i_act_tot = 72'h0, i_act_fund = 72'h0, i_rea_tot = 72'h0, i_rea_fund = 72'h0;
  wire [7:0]  o_rd_data;
  wire [2:0]  o_peak_phase_enable;
  wire [15:0] o_status_zero_set;
  wire        o_accum_valid;
  wire [71:0] pw [0:7];         // Conditioned outputs, energy then pulse.
  reg [7:0]  mm = 8'h1c;        // Model of the mode select register.
  reg [7:0]  am = 8'h00;        // Model of the accumulation mode register.
  reg [2:0]  pa = 3'h0, pr = 3'h0; // Last selected signs per phase.
  reg        have_prev = 1'b0;  // No reversal is reported before a first sample.
  integer    err_count = 0, checks_done = 0, seed = 32'h9392, tmp, i, j, k;

  energy_accum_mode_config i_energy_accum_mode_config (.i_clk_sys, .i_arst_n, .i_soft_reset, .i_addr,
    .i_wr_data, .i_wr_en, .i_rd_en, .o_rd_data, .i_power_valid, .i_act_tot, .i_act_fund, .i_rea_tot,
    .i_rea_fund, .o_peak_phase_enable, .o_status_zero_set, .o_accum_valid, .o_act_tot_energy(pw[0]),
    .o_act_fund_energy(pw[1]), .o_act_tot_pulse(pw[2]), .o_act_fund_pulse(pw[3]), .o_rea_tot_energy(pw[4]),
    .o_rea_fund_energy(pw[5]), .o_rea_tot_pulse(pw[6]), .o_rea_fund_pulse(pw[7]));

  // Free running 25 MHz clock.
  initial begin
    forever #20 i_clk_sys = ~i_clk_sys;
  end

  // Saturating negation and magnitude, so the most negative value stays in range.
  function [23:0] ng(input [23:0] v); ng = (v == 24'h800000) ? 24'h7fffff : 24'h0 - v; endfunction
  function [23:0] ab(input [23:0] v); ab = v[23] ? ng(v) : v; endfunction
  // Random sample that sometimes hits the most negative value.
  function [23:0] r24(input integer v); r24 = (v[28:24] == 5'h0) ? 24'h800000 : v[23:0]; endfunction
  // Expected energy, pulse and reactive paths for the current modes.
  function [23:0] em(input [23:0] v);
    case (am[1:0])
      2'h1: em = v[23] ? 24'h0 : v;
      2'h3: em = ab(v);
      default: em = v;
    endcase
  endfunction
  function [23:0] pm(input [23:0] v); pm = (am[1:0] == 2'h3) ? ab(v) : v; endfunction
  function [23:0] rm(input [23:0] v, input [23:0] a);
    case (am[3:2])
      2'h2: rm = a[23] ? ng(v) : v;
      2'h3: rm = ab(v);
      default: rm = v;
    endcase
  endfunction

  // Shared comparison; the typed tasks below funnel into it.
  task cmp(input [71:0] got, input [71:0] exp);
    begin
      checks_done = checks_done + 1;
      if (got !== exp) begin
        err_count = err_count + 1;
        $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
      end
    end
  endtask
  task chk_reg(input [7:0] g, input [7:0] e); cmp({64'h0, g}, {64'h0, e}); endtask
  task chk_stat(input [15:0] g, input [15:0] e); cmp({56'h0, g}, {56'h0, e}); endtask
  task chk_pwr(input [71:0] g, input [71:0] e); cmp(g, e); endtask

  // One write cycle; the model follows only the two writable registers.
  task wr_reg(input [15:0] a, input [7:0] d);
    begin
      @(posedge i_clk_sys);
      i_addr <= a;
      i_wr_data <= d;
      i_wr_en <= 1'b1;
      @(posedge i_clk_sys);
      i_wr_en <= 1'b0;
      if (a == 16'he700) mm = d;
      else if (a == 16'he701) am = d;
    end
  endtask

  // One read cycle; data is looked at in the following cycle only.
  task rd_chk(input [15:0] a, input [7:0] e);
    begin
      @(posedge i_clk_sys);
      i_addr <= a;
      i_rd_en <= 1'b1;
      @(posedge i_clk_sys);
      i_rd_en <= 1'b0;
      #1;
      chk_reg(o_rd_data, e);
    end
  endtask

  // One random sample set on all phases, compared one cycle later.
  task send;
    reg [71:0] na, nf, nr, nq;
    reg [71:0] e [0:7];
    reg [23:0] x, f, r, q;
    reg [15:0] es;
    reg        sa, sr;
    integer    p;
    begin
      es = 16'h0;
      for (p = 0; p < 3; p = p + 1) begin
        x = r24($random(seed));
        f = r24($random(seed));
        r = r24($random(seed));
        q = r24($random(seed));
        na[p*24 +: 24] = x;
        nf[p*24 +: 24] = f;
        nr[p*24 +: 24] = r;
        nq[p*24 +: 24] = q;
        e[0][p*24 +: 24] = em(x);
        e[1][p*24 +: 24] = em(f);
        e[2][p*24 +: 24] = pm(x);
        e[3][p*24 +: 24] = pm(f);
        e[4][p*24 +: 24] = rm(r, x);
        e[5][p*24 +: 24] = rm(q, f);
        e[6][p*24 +: 24] = rm(r, x);
        e[7][p*24 +: 24] = rm(q, f);
        sa = mm[0] ? f[23] : x[23];
        sr = mm[1] ? q[23] : r[23];
        es[6 + p] = have_prev && sa != pa[p];
        es[10 + p] = have_prev && sr != pr[p];
        pa[p] = sa;
        pr[p] = sr;
      end
      have_prev = 1'b1;
      @(posedge i_clk_sys);
      i_act_tot <= na;
      i_act_fund <= nf;
      i_rea_tot <= nr;
      i_rea_fund <= nq;
      i_power_valid <= 1'b1;
      @(posedge i_clk_sys);
      i_power_valid <= 1'b0;
      #1;
      chk_stat(o_status_zero_set, es);
      for (p = 0; p < 8; p = p + 1) chk_pwr(pw[p], e[p]);
    end
  endtask

  // Prints the counts and the verdict, then ends the run.
  task tally_and_finish;
    begin
      $display("Checks %0d, errors %0d", checks_done, err_count);
      if (err_count == 0 && checks_done > 0) $display("Finished cleanly");
      else $display("Finished with errors");
      $finish;
    end
  endtask

  // Cuts a hang short well beyond the roughly 1350 cycles the tests need.
  initial begin
    #(40 * 20000);
    err_count = err_count + 1;
    tally_and_finish;
  end

  initial begin
    repeat (2) @(posedge i_clk_sys);
    i_arst_n <= 1'b1;
    #1;
    chk_reg({5'h0, o_peak_phase_enable}, 8'h07);
    rd_chk(16'he700, 8'h1c);
    rd_chk(16'he701, 8'h00);
    rd_chk(16'he702, 8'h00);
    // Every source select pair and every mode pair, with junk in the reserved bits.
    for (i = 0; i < 8; i = i + 1) begin
      tmp = $random(seed);
      wr_reg(16'he700, {tmp[7:2], i[1:0]});
      rd_chk(16'he700, mm);
      chk_reg({5'h0, o_peak_phase_enable}, {5'h0, mm[4:2]});
      for (j = 0; j < 16; j = j + 1) begin
        tmp = $random(seed);
        wr_reg(16'he701, {tmp[7:4], j[3:0]});
        rd_chk(16'he701, am);
        for (k = 0; k < 3; k = k + 1) send;
      end
    end
    // The read-only sign register ignores writes and shows the last signs.
    wr_reg(16'he703, 8'hff);
    rd_chk(16'he703, {2'h0, pr, pa});
    // Soft reset beats a write in the same cycle and leaves the detectors alone.
    wr_reg(16'he700, 8'he3);
    @(posedge i_clk_sys);
    i_soft_reset <= 1'b1;
    i_addr <= 16'he701;
    i_wr_data <= 8'hff;
    i_wr_en <= 1'b1;
    @(posedge i_clk_sys);
    i_soft_reset <= 1'b0;
    i_wr_en <= 1'b0;
    mm = 8'h1c;
    am = 8'h00;
    rd_chk(16'he700, 8'h1c);
    rd_chk(16'he701, 8'h00);
    send;
    // A hard reset in mid-run restores defaults and forgets the last signs.
    wr_reg(16'he701, 8'h0f);
    @(posedge i_clk_sys);
    i_arst_n <= 1'b0;
    @(posedge i_clk_sys);
    i_arst_n <= 1'b1;
    mm = 8'h1c;
    am = 8'h00;
    have_prev = 1'b0;
    rd_chk(16'he701, 8'h00);
    send;
    send;
    tally_and_finish;
  end
endmodule // energy_accum_mode_config_bench
